// ### oled_pkg.sv
// package: register layout and constants for the over-level event detector
package oled_pkg;
  localparam int unsigned THR_W = 24;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned NUM_PH = 3;
  // register selects on the internal register port
  localparam logic [1:0] SEL_EVENT_STATUS_REG_ONE = 2'h0;
  localparam logic [1:0] SEL_EVENT_MASK_REG_ONE = 2'h1;
  localparam logic [1:0] SEL_OVTHR = 2'h2;
  localparam logic [1:0] SEL_OITHR = 2'h3;
  // field positions
  localparam int unsigned OV_BIT = 18;
  localparam int unsigned OI_BIT = 17;
  localparam int unsigned OVPH_LSB = 9;
  localparam int unsigned OIPH_LSB = 3;
  // reset values
  localparam logic [23:0] THR_RST = 24'h000000;
  localparam logic [31:0] MASK_RST = 32'h00000000;
  // highest magnitude the high-pass filter can produce
  localparam logic [23:0] HPF_MAX = 24'h5a7540;
  // register port answer states
  typedef enum logic [1:0] {
    OLED_IDLE,
    OLED_ANSWER
  } oled_port_t;
endpackage

// ### oled_detector.sv
// over-level event detector for three-phase voltage and current samples
`timescale 1ns/100ps
module oled_detector
  import oled_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic sample_valid,
  input wire logic signed [23:0] volt_a,
  input wire logic signed [23:0] volt_b,
  input wire logic signed [23:0] volt_c,
  input wire logic signed [23:0] curr_a,
  input wire logic signed [23:0] curr_b,
  input wire logic signed [23:0] curr_c,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [1:0] reg_sel,
  input wire logic [31:0] reg_wdata,
  input wire logic phase_rd,
  output logic [31:0] reg_rdata,
  output logic reg_ack,
  output logic [15:0] phase_event_status,
  output logic event_irq_n
);

  logic [23:0] overvoltage_threshold_ff, nxt_overvoltage_threshold;
  logic [23:0] overcurrent_threshold_ff, nxt_overcurrent_threshold;
  logic [31:0] event_mask_reg_one_ff, nxt_event_mask_reg_one;
  logic overvoltage_flag_ff, nxt_overvoltage_flag;
  logic overcurrent_flag_ff, nxt_overcurrent_flag;
  logic [2:0] overvoltage_phase_bits_ff, nxt_overvoltage_phase_bits;
  logic [2:0] overcurrent_phase_bits_ff, nxt_overcurrent_phase_bits;
  logic [31:0] reg_rdata_ff, nxt_reg_rdata;
  logic reg_ack_ff, nxt_reg_ack;
  logic [15:0] phase_stat_ff, nxt_phase_stat;
  logic irq_n_ff, nxt_irq_n;
  oled_port_t port_st_ff, nxt_port_st;
  logic [2:0] ov_hit, oi_hit;
  logic [23:0] v_mag [NUM_PH];
  logic [23:0] i_mag [NUM_PH];
  logic signed [23:0] v_in [NUM_PH];
  logic signed [23:0] i_in [NUM_PH];
  logic [31:0] status_word;
  logic clr_ov, clr_oi;

  assign v_in[0] = volt_a;
  assign v_in[1] = volt_b;
  assign v_in[2] = volt_c;
  assign i_in[0] = curr_a;
  assign i_in[1] = curr_b;
  assign i_in[2] = curr_c;

  // per-phase magnitude and strict greater-than compare
  generate
    for (genvar p = 0; p < NUM_PH; p++) begin : g_ph
      assign v_mag[p] = v_in[p][23] ? 24'(-v_in[p]) : v_in[p];
      assign i_mag[p] = i_in[p][23] ? 24'(-i_in[p]) : i_in[p];
      // a threshold at or above the filter maximum never detects, and a
      // zero threshold detects every valid sample, zero samples included
      assign ov_hit[p] = sample_valid &&
        (overvoltage_threshold_ff < HPF_MAX) &&
        ((v_mag[p] > overvoltage_threshold_ff) ||
        (overvoltage_threshold_ff == 24'h000000));
      assign oi_hit[p] = sample_valid &&
        (overcurrent_threshold_ff < HPF_MAX) &&
        ((i_mag[p] > overcurrent_threshold_ff) ||
        (overcurrent_threshold_ff == 24'h000000));
    end
  endgenerate

  // write-one-to-clear strobes for the first status register
  assign clr_ov = reg_wr && (reg_sel == SEL_EVENT_STATUS_REG_ONE) &&
    reg_wdata[OV_BIT];
  assign clr_oi = reg_wr && (reg_sel == SEL_EVENT_STATUS_REG_ONE) &&
    reg_wdata[OI_BIT];

  // status word as seen by the host
  always_comb begin
    status_word = '0;
    status_word[OV_BIT] = overvoltage_flag_ff;
    status_word[OI_BIT] = overcurrent_flag_ff;
  end

  // next-state: thresholds, mask, flags, phase bits, irq, read port
  always_comb begin
    nxt_overvoltage_threshold = overvoltage_threshold_ff;
    nxt_overcurrent_threshold = overcurrent_threshold_ff;
    nxt_event_mask_reg_one = event_mask_reg_one_ff;
    nxt_overvoltage_flag = overvoltage_flag_ff;
    nxt_overcurrent_flag = overcurrent_flag_ff;
    nxt_overvoltage_phase_bits = overvoltage_phase_bits_ff;
    nxt_overcurrent_phase_bits = overcurrent_phase_bits_ff;
    nxt_reg_rdata = reg_rdata_ff;
    nxt_reg_ack = 1'b0;
    nxt_port_st = OLED_IDLE;
    nxt_phase_stat = '0;
    // register writes; upper 8 bits of threshold words are dropped
    if (reg_wr) begin
      case (reg_sel)
        SEL_EVENT_MASK_REG_ONE: nxt_event_mask_reg_one = reg_wdata;
        SEL_OVTHR: nxt_overvoltage_threshold = reg_wdata[23:0];
        SEL_OITHR: nxt_overcurrent_threshold = reg_wdata[23:0];
        default: nxt_event_mask_reg_one = event_mask_reg_one_ff;
      endcase
    end
    // clear first, then set so a same-cycle event survives
    if (clr_ov) begin
      nxt_overvoltage_flag = 1'b0;
      nxt_overvoltage_phase_bits = '0;
    end
    if (clr_oi) begin
      nxt_overcurrent_flag = 1'b0;
      nxt_overcurrent_phase_bits = '0;
    end
    if (|ov_hit) begin
      nxt_overvoltage_flag = 1'b1;
    end
    if (|oi_hit) begin
      nxt_overcurrent_flag = 1'b1;
    end
    // sticky, accumulating phase identification
    nxt_overvoltage_phase_bits = nxt_overvoltage_phase_bits | ov_hit;
    nxt_overcurrent_phase_bits = nxt_overcurrent_phase_bits | oi_hit;
    // register reads answer one cycle later; threshold reads have top 8 bits zero
    case (port_st_ff)
      OLED_IDLE: begin
        if (reg_rd) begin
          nxt_port_st = OLED_ANSWER;
          case (reg_sel)
            SEL_EVENT_STATUS_REG_ONE: nxt_reg_rdata = status_word;
            SEL_EVENT_MASK_REG_ONE: nxt_reg_rdata = event_mask_reg_one_ff;
            SEL_OVTHR:
              nxt_reg_rdata = {8'h00, overvoltage_threshold_ff};
            SEL_OITHR:
              nxt_reg_rdata = {8'h00, overcurrent_threshold_ff};
            default: nxt_reg_rdata = '0;
          endcase
          nxt_reg_ack = 1'b1;
        end
      end
      OLED_ANSWER: nxt_port_st = OLED_IDLE;
      default: nxt_port_st = OLED_IDLE;
    endcase
    // live phase status view, refreshed each cycle
    nxt_phase_stat[OVPH_LSB +: 3] = nxt_overvoltage_phase_bits;
    nxt_phase_stat[OIPH_LSB +: 3] = nxt_overcurrent_phase_bits;
    // irq low while any enabled flag remains set
    nxt_irq_n = !(
      (nxt_overvoltage_flag && event_mask_reg_one_ff[OV_BIT]) ||
      (nxt_overcurrent_flag && event_mask_reg_one_ff[OI_BIT]));
  end

  // register all state; clock enable freezes everything
  always_ff @(posedge core_clk) begin
    if (rst) begin
      overvoltage_threshold_ff <= THR_RST;
      overcurrent_threshold_ff <= THR_RST;
      event_mask_reg_one_ff <= MASK_RST;
      overvoltage_flag_ff <= 1'b0;
      overcurrent_flag_ff <= 1'b0;
      overvoltage_phase_bits_ff <= '0;
      overcurrent_phase_bits_ff <= '0;
      reg_rdata_ff <= '0;
      reg_ack_ff <= 1'b0;
      phase_stat_ff <= '0;
      irq_n_ff <= 1'b1;
      port_st_ff <= OLED_IDLE;
    end else if (clk_en) begin
      overvoltage_threshold_ff <= nxt_overvoltage_threshold;
      overcurrent_threshold_ff <= nxt_overcurrent_threshold;
      event_mask_reg_one_ff <= nxt_event_mask_reg_one;
      overvoltage_flag_ff <= nxt_overvoltage_flag;
      overcurrent_flag_ff <= nxt_overcurrent_flag;
      overvoltage_phase_bits_ff <= nxt_overvoltage_phase_bits;
      overcurrent_phase_bits_ff <= nxt_overcurrent_phase_bits;
      reg_rdata_ff <= nxt_reg_rdata;
      reg_ack_ff <= nxt_reg_ack;
      phase_stat_ff <= nxt_phase_stat;
      irq_n_ff <= nxt_irq_n;
      port_st_ff <= nxt_port_st;
    end
  end

  assign reg_rdata = reg_rdata_ff;
  assign reg_ack = reg_ack_ff;
  assign phase_event_status = phase_stat_ff;
  assign event_irq_n = irq_n_ff;

  // detection, flags and phase identification
  a_ov_sets_flag: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && (|ov_hit) |=> overvoltage_flag_ff)
    else $error("overvoltage flag not set");
  a_oi_sets_flag: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && (|oi_hit)
    |=> overcurrent_flag_ff && phase_event_status[OIPH_LSB +: 3] != 3'h0)
    else $error("overcurrent flag or phase bit missing");
  a_ov_phase_bits: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && ov_hit[0] |=> phase_event_status[OVPH_LSB])
    else $error("phase a overvoltage bit missing");
  a_oi_phase_bits: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && oi_hit[1] |=> phase_event_status[OIPH_LSB + 1])
    else $error("phase b overcurrent bit missing");
  a_sticky_phase: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && overvoltage_phase_bits_ff[2] && !clr_ov
    |=> overvoltage_phase_bits_ff[2])
    else $error("phase bit lost without clear");
  // interrupt pin
  a_ov_irq_low: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && (|ov_hit) && event_mask_reg_one_ff[OV_BIT]
    |=> !event_irq_n)
    else $error("irq not driven low on overvoltage");
  a_oi_irq_low: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && (|oi_hit) && event_mask_reg_one_ff[OI_BIT]
    |=> !event_irq_n)
    else $error("irq not driven low on overcurrent");
  a_irq_high_idle: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && !overvoltage_flag_ff && !overcurrent_flag_ff &&
    !(|ov_hit) && !(|oi_hit) |=> event_irq_n)
    else $error("irq low with no flag set");
  a_irq_mask_off: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && !event_mask_reg_one_ff[OV_BIT] &&
    !event_mask_reg_one_ff[OI_BIT] |=> event_irq_n)
    else $error("irq low with both masks off");
  a_irq_held_low: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && overvoltage_flag_ff && !clr_ov &&
    event_mask_reg_one_ff[OV_BIT] |=> !event_irq_n)
    else $error("irq released while enabled flag set");
  // write-one-to-clear
  a_ov_clear: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && clr_ov && !(|ov_hit) |=> !overvoltage_flag_ff &&
    overvoltage_phase_bits_ff == 3'h0)
    else $error("overvoltage clear failed");
  a_oi_clear: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && clr_oi && !(|oi_hit) |=> !overcurrent_flag_ff &&
    overcurrent_phase_bits_ff == 3'h0)
    else $error("overcurrent clear failed");
  a_ov_clear_irq: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && clr_ov && !(|ov_hit) && !(|oi_hit) &&
    !(overcurrent_flag_ff && event_mask_reg_one_ff[OI_BIT])
    |=> event_irq_n)
    else $error("irq not released by overvoltage clear");
  a_oi_clear_irq: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && clr_oi && !(|oi_hit) && !(|ov_hit) &&
    !(overvoltage_flag_ff && event_mask_reg_one_ff[OV_BIT])
    |=> event_irq_n)
    else $error("irq not released by overcurrent clear");
  // register port
  a_status_layout: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && port_st_ff == OLED_IDLE && reg_rd && reg_sel == SEL_EVENT_STATUS_REG_ONE
    |=> reg_rdata[31:19] == 13'h0000 &&
    reg_rdata[16:0] == 17'h00000)
    else $error("status read has spare bits set");
  a_read_top_zero: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && port_st_ff == OLED_IDLE && reg_rd && reg_sel == SEL_OVTHR
    |=> reg_ack && reg_rdata[31:24] == 8'h00)
    else $error("threshold read top byte not zero");
  a_thr_write_low: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && reg_wr && reg_sel == SEL_OITHR
    |=> overcurrent_threshold_ff == 24'($past(reg_wdata)))
    else $error("threshold write lost low bits");
  a_ack_one_cycle: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && reg_ack |=> !reg_ack)
    else $error("read ack longer than one cycle");
  a_ack_after_read: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && port_st_ff == OLED_IDLE && reg_rd |=> reg_ack)
    else $error("read not answered");
  // threshold limits
  a_max_never_hit: assert property (
    @(posedge core_clk) disable iff (rst)
    overvoltage_threshold_ff == HPF_MAX |-> !ov_hit[1])
    else $error("overvoltage at maximum threshold");
  a_oi_max_never: assert property (
    @(posedge core_clk) disable iff (rst)
    overcurrent_threshold_ff == HPF_MAX |-> !oi_hit[2])
    else $error("overcurrent at maximum threshold");
  a_zero_always_hit: assert property (
    @(posedge core_clk) disable iff (rst)
    sample_valid && overvoltage_threshold_ff == 24'h000000
    |-> ov_hit[1])
    else $error("zero threshold did not detect");
  // clock enable
  a_frozen_state: assert property (
    @(posedge core_clk) disable iff (rst)
    !clk_en
    |=> $stable(overvoltage_flag_ff) && $stable(event_irq_n))
    else $error("state moved with clock enable low");

endmodule

// ### oled_host.sv
// host model that drives the register port of the over-level detector
`timescale 1ns/100ps
module oled_host
  import oled_pkg::*;
(
  input wire logic core_clk,
  input wire logic reg_ack,
  input wire logic [31:0] reg_rdata,
  input wire logic [15:0] phase_event_status,
  input wire logic event_irq_n,
  output logic reg_wr,
  output logic reg_rd,
  output logic [1:0] reg_sel,
  output logic [31:0] reg_wdata
);
  // idle port at time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_sel = 2'h0;
    reg_wdata = 32'h00000000;
  end
  // one write, then an idle cycle so strobes never toggle twice at once
  task automatic wr(input logic [1:0] sel, input logic [31:0] data);
    reg_sel = sel;
    reg_wdata = (sel >= SEL_OVTHR) ? {8'h00, data[23:0]} : data;
    reg_wr = 1'b1;
    @(posedge core_clk);
    #2;
    reg_wr = 1'b0;
    @(posedge core_clk);
    #2;
  endtask
  // one read; the bounded wait also keeps reads apart
  task automatic rd(input logic [1:0] sel, output logic [31:0] data,
                    output logic ok);
    int n;
    reg_sel = sel;
    reg_rd = 1'b1;
    @(posedge core_clk);
    #2;
    reg_rd = 1'b0;
    ok = 1'b0;
    data = 32'h00000000;
    for (n = 0; n < 4; n++) begin
      if (reg_ack === 1'b1 && !ok) begin
        ok = 1'b1;
        data = reg_rdata;
      end
      @(posedge core_clk);
      #2;
    end
  endtask
  // interrupt service: wait for the pin, read status, then phases, clear
  task automatic service(input int b, output logic [31:0] st,
                         output logic [15:0] ph, output logic ok);
    int n;
    logic low;
    for (n = 0; n < 8 && event_irq_n !== 1'b0; n++) begin
      @(posedge core_clk);
      #2;
    end
    // a pin that never fell fails the service like a lost ack
    low = (event_irq_n === 1'b0);
    rd(SEL_EVENT_STATUS_REG_ONE, st, ok);
    ph = phase_event_status;
    wr(SEL_EVENT_STATUS_REG_ONE, 32'h00000001 << b);
    ok = ok & low;
  endtask
endmodule

// ### oled_detector_tb.sv
// testbench for the over-level event detector
`timescale 1ns/100ps
module oled_detector_tb
  import oled_pkg::*;
;
  logic core_clk, rst, clk_en, sample_valid, phase_rd, reg_wr, reg_rd;
  logic reg_ack, event_irq_n, ok;
  logic [1:0] reg_sel;
  logic [31:0] reg_wdata, reg_rdata, st;
  logic [15:0] phase_event_status, ph;
  logic signed [23:0] smp [6];
  int error_cnt = 0;
  int checks_done = 0;
  oled_detector dut (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
    .sample_valid(sample_valid), .volt_a(smp[0]), .volt_b(smp[1]),
    .volt_c(smp[2]), .curr_a(smp[3]), .curr_b(smp[4]), .curr_c(smp[5]),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_sel(reg_sel),
    .reg_wdata(reg_wdata), .phase_rd(phase_rd), .reg_rdata(reg_rdata),
    .reg_ack(reg_ack), .phase_event_status(phase_event_status),
    .event_irq_n(event_irq_n));
  oled_host h (.core_clk(core_clk), .reg_ack(reg_ack),
    .reg_rdata(reg_rdata), .phase_event_status(phase_event_status),
    .event_irq_n(event_irq_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_sel(reg_sel), .reg_wdata(reg_wdata));
  // 40 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // read a register and compare it
  task automatic rdchk(input logic [1:0] sel, input logic [31:0] exp);
    h.rd(sel, st, ok);
    chk("ack", {31'h0, ok}, 32'h1);
    chk("rdata", st, exp);
  endtask
  // one valid sample on one channel, then an idle cycle
  task automatic fire(input int idx, input logic [23:0] val);
    smp[idx] = val;
    sample_valid = 1'b1;
    @(posedge core_clk);
    #2;
    sample_valid = 1'b0;
    smp[idx] = 24'h000000;
    @(posedge core_clk);
    #2;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // hang guard
  initial begin
    #2500000;
    $display("BAD run timeout");
    error_cnt++;
    final_report();
  end
  // main sequence
  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    sample_valid = 1'b0;
    phase_rd = 1'b0;
    for (int i = 0; i < 6; i++) smp[i] = 24'h000000;
    repeat (2) @(posedge core_clk);
    #2;
    rst = 1'b0;
    chk("irq", {31'h0, event_irq_n}, 32'h1);
    chk("phase", {16'h0, phase_event_status}, 32'h0);
    // a sample while the clock enable is low must leave no trace
    clk_en = 1'b0;
    fire(0, 24'h000001);
    clk_en = 1'b1;
    chk("frozen", {16'h0, phase_event_status}, 32'h0);
    rdchk(SEL_EVENT_STATUS_REG_ONE, 32'h0);
    rdchk(SEL_EVENT_MASK_REG_ONE, MASK_RST);
    $display("test reset done");
    h.wr(SEL_OVTHR, 32'hff001000);
    h.wr(SEL_OITHR, 32'h00000800);
    rdchk(SEL_OVTHR, 32'h00001000);
    rdchk(SEL_OITHR, 32'h00000800);
    h.wr(SEL_EVENT_MASK_REG_ONE, 32'h1 << OI_BIT);
    fire(0, 24'h001000);
    rdchk(SEL_EVENT_STATUS_REG_ONE, 32'h0);
    fire(0, 24'hffefff);
    chk("irq", {31'h0, event_irq_n}, 32'h1);
    chk("phase", {16'h0, phase_event_status}, 32'h200);
    rdchk(SEL_EVENT_STATUS_REG_ONE, 32'h1 << OV_BIT);
    h.wr(SEL_EVENT_MASK_REG_ONE, 32'h3 << OI_BIT);
    chk("irq", {31'h0, event_irq_n}, 32'h0);
    fire(2, 24'h001001);
    fire(4, 24'hfff7ff);
    chk("phase", {16'h0, phase_event_status}, 32'ha10);
    $display("test detect done");
    h.service(OI_BIT, st, ph, ok);
    chk("ack", {31'h0, ok}, 32'h1);
    chk("status", st, 32'h3 << OI_BIT);
    chk("phase", {16'h0, ph}, 32'ha10);
    chk("phase", {16'h0, phase_event_status}, 32'ha00);
    chk("irq", {31'h0, event_irq_n}, 32'h0);
    h.service(OV_BIT, st, ph, ok);
    chk("ack", {31'h0, ok}, 32'h1);
    chk("status", st, 32'h1 << OV_BIT);
    chk("phase", {16'h0, ph}, 32'ha00);
    chk("phase", {16'h0, phase_event_status}, 32'h0);
    chk("irq", {31'h0, event_irq_n}, 32'h1);
    h.wr(SEL_EVENT_MASK_REG_ONE, 32'h1 << OI_BIT);
    fire(3, 24'h000801);
    chk("irq", {31'h0, event_irq_n}, 32'h0);
    chk("phase", {16'h0, phase_event_status}, 32'h8);
    h.wr(SEL_EVENT_STATUS_REG_ONE, 32'h1 << OI_BIT);
    chk("irq", {31'h0, event_irq_n}, 32'h1);
    $display("test clear done");
    h.wr(SEL_OVTHR, {8'h00, HPF_MAX});
    h.wr(SEL_OITHR, {8'h00, HPF_MAX});
    h.wr(SEL_EVENT_MASK_REG_ONE, 32'h3 << OI_BIT);
    fire(1, HPF_MAX);
    fire(5, 24'h000000 - HPF_MAX);
    chk("irq", {31'h0, event_irq_n}, 32'h1);
    rdchk(SEL_EVENT_STATUS_REG_ONE, 32'h0);
    h.wr(SEL_OVTHR, 32'h00000000);
    fire(1, 24'h000001);
    h.wr(SEL_EVENT_STATUS_REG_ONE, 32'h1 << OV_BIT);
    fire(1, 24'hffffff);
    chk("irq", {31'h0, event_irq_n}, 32'h0);
    // zero threshold: even zero samples flag all three phases
    h.wr(SEL_EVENT_STATUS_REG_ONE, 32'h1 << OV_BIT);
    fire(1, 24'h000000);
    chk("phase", {16'h0, phase_event_status}, 32'he00);
    chk("irq", {31'h0, event_irq_n}, 32'h0);
    // clear and event on the same edge: the event wins
    fork
      h.wr(SEL_EVENT_STATUS_REG_ONE, 32'h1 << OV_BIT);
      fire(0, 24'h000000);
    join
    chk("phase", {16'h0, phase_event_status}, 32'he00);
    rdchk(SEL_EVENT_STATUS_REG_ONE, 32'h1 << OV_BIT);
    $display("test threshold limits done");
    final_report();
  end
endmodule
